// *** rtl/hrcs_sequencer.sv ***
// hub reset, configuration and upstream bus reset sequencer
//
// Contract
// RULE1 - reset source holds hardware reset low at least 1 us.
// RULE2 - strap mode: outputs at inactive levels at most 2 us after release.
// RULE3 - strap and memory modes: attach within 100 ms of configuration done.
// RULE4 - operational at most 500 us after reset release, before configuring.
// RULE5 - memory load finishes within 99.5 ms, else it is abandoned.
// RULE6 - smbus mode, self-powered: wait for settings load without limit.
// RULE7 - smbus mode, bus-powered: host loads settings within 99.5 ms.
// RULE8 - smbus mode: attach within 100 ms after settings load ends.
// RULE9 - host waits at least 100 ms after attach before bus reset.
// RULE10 - every upstream request finishes within 5 ms.
// RULE11 - upstream bus reset returns device address to zero.
// RULE12 - upstream bus reset drops the device into unconfigured state.
// RULE13 - upstream bus reset clears port power unless charging enabled.
// RULE14 - upstream bus reset empties all translator buffers.
// RULE15 - upstream bus reset while suspended makes the hub active.
// RULE16 - upstream bus reset never reaches downstream ports.
// RULE17 - config-select straps sampled at release choose the config path.
`include "hrcs_defs.svh"
module hrcs_sequencer
  import hrcs_pkg::*;
#(
  parameter int NPORTS = 4,
  parameter int OPER_CYC = $rtoi(`HRCS_T_OPER_MAX_US * 1000.0 / `HRCS_CLK_NS),
  parameter int MEM_MAX_CYC = $rtoi(`HRCS_T_MEM_MAX_MS * 1.0e6 / `HRCS_CLK_NS),
  parameter int SMB_MAX_CYC = $rtoi(`HRCS_T_SMB_BUS_MAX_MS * 1.0e6 / `HRCS_CLK_NS),
  parameter int REQ_MAX_CYC = $rtoi(`HRCS_T_REQ_MAX_MS * 1.0e6 / `HRCS_CLK_NS)
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] cfgSelPin,
  input wire logic selfPoweredPin,
  input wire logic memLoadDone,
  input wire logic usbBusReset,
  input wire logic suspendEnter,
  input wire logic resumeDetect,
  input wire logic reqActive,
  output logic hubOutputsDriven,
  output logic operational,
  output logic memLoadReq,
  output logic upstreamAttach,
  output logic [6:0] devAddress,
  output logic configured,
  output logic hubSuspended,
  output logic ttFlush,
  output logic reqAbort,
  output logic [NPORTS-1:0] downstreamPortPowerEn,
  output logic [NPORTS-1:0] chargingPortEnable,
  output logic [NPORTS-1:0] downstreamPortReset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int INACTIVE_CYC = $rtoi(`HRCS_T_INACTIVE_MAX_US * 1000.0 / `HRCS_CLK_NS);
  localparam int ATTACH_MAX_CYC = $rtoi(`HRCS_T_ATTACH_MAX_MS * 1.0e6 / `HRCS_CLK_NS);
  localparam int CW = 32;

  hrcs_reg_if regs ();

  logic [1:0] cfgSync1;
  logic [1:0] cfgSync2;
  logic spSync1;
  logic spSync2;
  hrcs_state_t state;
  hrcs_cfg_t cfgPath;
  logic selfPowered;
  logic [CW-1:0] seqCnt;
  logic [CW-1:0] reqCnt;
  logic reqAborted;
  logic loadDone;
  logic memErr;
  logic smbLate;
  logic reqTmo;
  logic wrCtrl;
  logic wrStatus;
  logic wrPortRst;

  assign wrCtrl = regs.wrEn && regs.wrAddr == `HRCS_REG_CTRL && regs.wrStrb[0];
  assign wrStatus = regs.wrEn && regs.wrAddr == `HRCS_REG_STATUS && regs.wrStrb[1];
  assign wrPortRst = regs.wrEn && regs.wrAddr == `HRCS_REG_PORTRST && regs.wrStrb[0];

  hrcs_axil_slave u_bus (
    .clk(clk),
    .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regs(regs)
  );

  // strap pins, two flops, running through reset
  always_ff @(posedge clk) begin
    cfgSync1 <= cfgSelPin;
    cfgSync2 <= cfgSync1;
    spSync1 <= selfPoweredPin;
    spSync2 <= spSync1;
  end

  // strap capture shortly after release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfgPath <= HRCS_CFG_STRAP;
      selfPowered <= 1'b0;
    end else if (state == HRCS_ST_RECOVER && seqCnt == CW'(`HRCS_STRAP_SETTLE)) begin
      cfgPath <= hrcs_cfg_t'(cfgSync2); // [RULE17]
      selfPowered <= spSync2;
    end
  end

  // configuration sequence
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= HRCS_ST_RECOVER;
      seqCnt <= '0;
      hubOutputsDriven <= 1'b0;
      operational <= 1'b0;
      memLoadReq <= 1'b0;
      upstreamAttach <= 1'b0;
    end else begin
      seqCnt <= seqCnt + CW'(1);
      unique case (state)
        HRCS_ST_RECOVER: begin
          if (seqCnt == CW'(INACTIVE_CYC - 1) || seqCnt == CW'(OPER_CYC - 1)) begin
            hubOutputsDriven <= 1'b1; // [RULE2]
          end
          if (seqCnt >= CW'(OPER_CYC - 1) && seqCnt > CW'(`HRCS_STRAP_SETTLE)) begin
            operational <= 1'b1; // [RULE4]
            seqCnt <= '0;
            unique case (cfgPath)
              HRCS_CFG_MEM: begin
                state <= HRCS_ST_MEMLOAD;
                memLoadReq <= 1'b1;
              end
              HRCS_CFG_SMB: state <= HRCS_ST_SMBWAIT;
              HRCS_CFG_STRAP, HRCS_CFG_RSVD: state <= HRCS_ST_APPLY;
            endcase
          end
        end
        HRCS_ST_MEMLOAD: begin
          if (memLoadDone || seqCnt >= CW'(MEM_MAX_CYC - 1)) begin
            memLoadReq <= 1'b0; // [RULE5]
            state <= HRCS_ST_APPLY;
          end
        end
        HRCS_ST_SMBWAIT: begin
          if (loadDone) begin
            state <= HRCS_ST_APPLY; // [RULE6]
          end
        end
        HRCS_ST_APPLY: begin
          upstreamAttach <= 1'b1; // [RULE3] [RULE8]
          state <= HRCS_ST_ATTACHED;
        end
        HRCS_ST_ATTACHED: seqCnt <= seqCnt;
      endcase
    end
  end

  // sticky error flags, hardware set wins over clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      memErr <= 1'b0;
      smbLate <= 1'b0;
      reqTmo <= 1'b0;
    end else begin
      memErr <= (state == HRCS_ST_MEMLOAD && !memLoadDone && seqCnt >= CW'(MEM_MAX_CYC - 1))
        || (memErr && !(wrStatus && regs.wrData[`HRCS_ST_MEMERR]));
      smbLate <= (state == HRCS_ST_SMBWAIT && !selfPowered && seqCnt == CW'(SMB_MAX_CYC - 1))
        || (smbLate && !(wrStatus && regs.wrData[`HRCS_ST_SMBLATE])); // [RULE7]
      reqTmo <= (reqActive && !reqAborted && reqCnt == CW'(REQ_MAX_CYC - 1))
        || (reqTmo && !(wrStatus && regs.wrData[`HRCS_ST_REQTMO]));
    end
  end

  // settings load done, set by the configuration host
  always_ff @(posedge clk) begin
    if (!rstn) begin
      loadDone <= 1'b0;
    end else if (wrCtrl && regs.wrData[`HRCS_CTRL_LOADDONE]) begin
      loadDone <= 1'b1;
    end
  end

  // upstream request watchdog
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reqCnt <= '0;
      reqAborted <= 1'b0;
      reqAbort <= 1'b0;
    end else begin
      reqAbort <= 1'b0;
      if (!reqActive || !upstreamAttach) begin
        reqCnt <= '0;
        reqAborted <= 1'b0;
      end else if (!reqAborted) begin
        reqCnt <= reqCnt + CW'(1);
        if (reqCnt == CW'(REQ_MAX_CYC - 1)) begin
          reqAbort <= 1'b1; // [RULE10]
          reqAborted <= 1'b1;
        end
      end
    end
  end

  // device address and configuration
  always_ff @(posedge clk) begin
    if (!rstn) begin
      devAddress <= `HRCS_RST_DEVADDR;
      configured <= 1'b0;
    end else if (usbBusReset) begin
      devAddress <= `HRCS_RST_DEVADDR; // [RULE11]
      configured <= 1'b0; // [RULE12]
    end else if (regs.wrEn && regs.wrStrb[0]) begin
      if (regs.wrAddr == `HRCS_REG_DEVADDR) begin
        devAddress <= regs.wrData[6:0];
      end
      if (regs.wrAddr == `HRCS_REG_CONFIG) begin
        configured <= regs.wrData[7:0] != `HRCS_RST_CONFIG;
      end
    end
  end

  // per-port power, charging enable and software port reset
  genvar p;
  generate
    for (p = 0; p < NPORTS; p++) begin : g_port
      always_ff @(posedge clk) begin
        if (!rstn) begin
          downstreamPortPowerEn[p] <= 1'b0;
          chargingPortEnable[p] <= 1'b0;
          downstreamPortReset[p] <= 1'b0;
        end else begin
          downstreamPortReset[p] <= wrPortRst && regs.wrData[p]; // [RULE16]
          if (regs.wrEn && regs.wrStrb[0] && regs.wrAddr == `HRCS_REG_CHARGE) begin
            chargingPortEnable[p] <= regs.wrData[p];
          end
          if (usbBusReset) begin
            downstreamPortPowerEn[p] <= downstreamPortPowerEn[p] && chargingPortEnable[p]; // [RULE13]
          end else if (regs.wrEn && regs.wrStrb[0] && regs.wrAddr == `HRCS_REG_PORTPWR) begin
            downstreamPortPowerEn[p] <= regs.wrData[p];
          end
        end
      end
    end
  endgenerate

  // suspend state and translator flush
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hubSuspended <= 1'b0;
      ttFlush <= 1'b0;
    end else begin
      ttFlush <= usbBusReset; // [RULE14]
      if (usbBusReset || resumeDetect) begin
        hubSuspended <= 1'b0; // [RULE15]
      end else if (suspendEnter) begin
        hubSuspended <= 1'b1;
      end
    end
  end

  // register read mux
  always_comb begin
    regs.rdData = 32'h0000_0000;
    case (regs.rdAddr)
      `HRCS_REG_CTRL: regs.rdData[`HRCS_CTRL_LOADDONE] = loadDone;
      `HRCS_REG_DEVADDR: regs.rdData[6:0] = devAddress;
      `HRCS_REG_CONFIG: regs.rdData[0] = configured;
      `HRCS_REG_PORTPWR: regs.rdData[NPORTS-1:0] = downstreamPortPowerEn;
      `HRCS_REG_CHARGE: regs.rdData[NPORTS-1:0] = chargingPortEnable;
      `HRCS_REG_STATUS: begin
        regs.rdData[`HRCS_ST_STATE_LSB +: 3] = state;
        regs.rdData[`HRCS_ST_PATH_LSB +: 2] = cfgPath;
        regs.rdData[`HRCS_ST_SELFPWR] = selfPowered;
        regs.rdData[`HRCS_ST_OPER] = operational;
        regs.rdData[`HRCS_ST_ATTACH] = upstreamAttach;
        regs.rdData[`HRCS_ST_SUSP] = hubSuspended;
        regs.rdData[`HRCS_ST_MEMERR] = memErr;
        regs.rdData[`HRCS_ST_SMBLATE] = smbLate;
        regs.rdData[`HRCS_ST_REQTMO] = reqTmo;
      end
      default: regs.rdData = 32'h0000_0000;
    endcase
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_outputs_inactive: assert property ( // [RULE2]
    $rose(rstn) |-> ##[0:INACTIVE_CYC] hubOutputsDriven)
    else $error("outputs not inactive in time");
  chk_oper_bound: assert property ( // [RULE4]
    (state == HRCS_ST_RECOVER) |-> seqCnt < CW'(OPER_CYC + `HRCS_STRAP_SETTLE))
    else $error("operational too late");
  chk_mem_bound: assert property ( // [RULE5]
    (state == HRCS_ST_MEMLOAD) |-> seqCnt < CW'(MEM_MAX_CYC))
    else $error("memory load overran");
  chk_attach_follows: assert property ( // [RULE3]
    (state == HRCS_ST_APPLY) |=> upstreamAttach && state == HRCS_ST_ATTACHED)
    else $error("attach did not follow configuration");
  chk_smb_self_wait: assert property ( // [RULE6]
    (state == HRCS_ST_SMBWAIT && !loadDone) |=> state == HRCS_ST_SMBWAIT)
    else $error("smbus wait left early");
  chk_smb_attach: assert property ( // [RULE8]
    (state == HRCS_ST_SMBWAIT && loadDone) |-> ##2 upstreamAttach && ATTACH_MAX_CYC > 2)
    else $error("smbus attach late");
  chk_req_abort: assert property ( // [RULE10]
    (reqActive && upstreamAttach && !reqAborted && reqCnt == CW'(REQ_MAX_CYC - 1))
      |=> reqAbort ##1 !reqAbort)
    else $error("request watchdog missed");
  chk_busrst_addr: assert property ( // [RULE11] [RULE12]
    usbBusReset |=> devAddress == 7'h00 && !configured)
    else $error("bus reset kept address or configuration");
  chk_busrst_power: assert property ( // [RULE13]
    usbBusReset |=> downstreamPortPowerEn ==
      ($past(downstreamPortPowerEn) & $past(chargingPortEnable)))
    else $error("bus reset port power wrong");
  chk_busrst_flush: assert property ( // [RULE14] [RULE15]
    usbBusReset |=> ttFlush && !hubSuspended)
    else $error("bus reset did not flush or resume");
  chk_no_forward: assert property ( // [RULE16]
    (usbBusReset && !wrPortRst) |=> downstreamPortReset == '0)
    else $error("bus reset forwarded downstream");
endmodule

// *** rtl/hrcs_defs.svh ***
// constants for the hub reset and configuration sequencer
`ifndef HRCS_DEFS_SVH
`define HRCS_DEFS_SVH

// register byte offsets
`define HRCS_REG_CTRL 8'h00
`define HRCS_REG_DEVADDR 8'h04
`define HRCS_REG_CONFIG 8'h08
`define HRCS_REG_PORTPWR 8'h0c
`define HRCS_REG_CHARGE 8'h10
`define HRCS_REG_STATUS 8'h14
`define HRCS_REG_PORTRST 8'h18
`define HRCS_REG_LAST 8'h18

// field positions
`define HRCS_CTRL_LOADDONE 0
`define HRCS_ST_STATE_LSB 0
`define HRCS_ST_PATH_LSB 3
`define HRCS_ST_SELFPWR 5
`define HRCS_ST_OPER 6
`define HRCS_ST_ATTACH 7
`define HRCS_ST_SUSP 8
`define HRCS_ST_MEMERR 9
`define HRCS_ST_SMBLATE 10
`define HRCS_ST_REQTMO 11

// reset values
`define HRCS_RST_DEVADDR 7'h00
`define HRCS_RST_CONFIG 8'h00

// bus responses
`define HRCS_RESP_OKAY 2'b00
`define HRCS_RESP_SLVERR 2'b10

// timing, each in its own unit
`define HRCS_CLK_NS 5.0
`define HRCS_T_INACTIVE_MAX_US 2.0
`define HRCS_T_OPER_MAX_US 500.0
`define HRCS_T_MEM_MAX_MS 99.5
`define HRCS_T_SMB_BUS_MAX_MS 99.5
`define HRCS_T_ATTACH_MAX_MS 100.0
`define HRCS_T_REQ_MAX_MS 5.0
`define HRCS_STRAP_SETTLE 3

`endif

// *** rtl/hrcs_pkg.sv ***
// types for the hub reset and configuration sequencer
package hrcs_pkg;
  typedef enum logic [2:0] {
    HRCS_ST_RECOVER = 3'b000,
    HRCS_ST_MEMLOAD = 3'b001,
    HRCS_ST_SMBWAIT = 3'b010,
    HRCS_ST_APPLY = 3'b011,
    HRCS_ST_ATTACHED = 3'b100
  } hrcs_state_t;

  typedef enum logic [1:0] {
    HRCS_CFG_STRAP = 2'b00,
    HRCS_CFG_MEM = 2'b01,
    HRCS_CFG_SMB = 2'b10,
    HRCS_CFG_RSVD = 2'b11
  } hrcs_cfg_t;
endpackage

// *** rtl/hrcs_reg_if.sv ***
// register access carrier between bus slave and sequencer core
interface hrcs_reg_if;
  logic wrEn;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  modport slave (output wrEn, wrAddr, wrData, wrStrb, rdAddr, input rdData);
  modport core (input wrEn, wrAddr, wrData, wrStrb, rdAddr, output rdData);
endinterface

// *** rtl/hrcs_axil_slave.sv ***
// axi4-lite slave feeding the sequencer registers
`include "hrcs_defs.svh"
module hrcs_axil_slave
  import hrcs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  hrcs_reg_if.slave regs
);
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic doWrite;
  logic next_awHeld;
  logic next_wHeld;
  logic next_bvalid;
  logic next_rvalid;
  logic arHs;

  function automatic logic addrHit(input logic [7:0] a);
    addrHit = (a[1:0] == 2'b00) && (a <= `HRCS_REG_LAST);
  endfunction

  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign next_awHeld = (awHeld || (s_axi_awvalid && s_axi_awready)) && !doWrite;
  assign next_wHeld = (wHeld || (s_axi_wvalid && s_axi_wready)) && !doWrite;
  assign next_bvalid = doWrite || (s_axi_bvalid && !s_axi_bready);
  assign arHs = s_axi_arvalid && s_axi_arready;
  assign next_rvalid = arHs || (s_axi_rvalid && !s_axi_rready);

  assign regs.wrEn = doWrite && addrHit(awAddr);
  assign regs.wrAddr = awAddr;
  assign regs.rdAddr = s_axi_araddr;

  // write address and data, taken in either order
  always_ff @(posedge clk) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      regs.wrData <= 32'h0000_0000;
      regs.wrStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      s_axi_awready <= !next_awHeld && !next_bvalid;
      s_axi_wready <= !next_wHeld && !next_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        regs.wrData <= s_axi_wdata;
        regs.wrStrb <= s_axi_wstrb;
      end
    end
  end

  // write response
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HRCS_RESP_OKAY;
    end else begin
      s_axi_bvalid <= next_bvalid;
      if (doWrite) begin
        s_axi_bresp <= addrHit(awAddr) ? `HRCS_RESP_OKAY : `HRCS_RESP_SLVERR;
      end
    end
  end

  // read channel
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `HRCS_RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (arHs) begin
        s_axi_rdata <= addrHit(s_axi_araddr) ? regs.rdData : 32'h0000_0000;
        s_axi_rresp <= addrHit(s_axi_araddr) ? `HRCS_RESP_OKAY : `HRCS_RESP_SLVERR;
      end
    end
  end
endmodule

// *** bench/hrcs_far_model.sv ***
// memory responder and upstream host model for the sequencer
module hrcs_far_model #(
  parameter int HOLDOFF = 40
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic memLoadReq,
  input wire logic upstreamAttach,
  input wire logic [7:0] memDelay,
  input wire logic hostResetGo,
  output logic memLoadDone,
  output logic usbBusReset
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] memCnt;
  int attachCnt;
  logic sent;
  // memory read answer, delay zero means silent
  always_ff @(posedge clk) begin
    if (!rstn || !memLoadReq) begin
      memCnt <= 8'h00;
      memLoadDone <= 1'b0;
    end else begin
      memCnt <= memCnt + 8'h01;
      memLoadDone <= (memDelay != 8'h00) && (memCnt == memDelay);
    end
  end
  // host holds off after attach before bus reset
  always_ff @(posedge clk) begin
    if (!rstn || !upstreamAttach) begin
      attachCnt <= 0;
    end else if (attachCnt < HOLDOFF) begin
      attachCnt <= attachCnt + 1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      usbBusReset <= 1'b0;
      sent <= 1'b0;
    end else begin
      usbBusReset <= hostResetGo && !sent && (attachCnt >= HOLDOFF);
      if (!hostResetGo) begin
        sent <= 1'b0;
      end else if (attachCnt >= HOLDOFF) begin
        sent <= 1'b1;
      end
    end
  end
endmodule

// *** bench/hrcs_sequencer_tb.sv ***
// self-checking bench for the sequencer
`include "hrcs_defs.svh"
module hrcs_sequencer_tb;
  import hrcs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OPER = 20;
  localparam int MEMMAX = 50;
  localparam int SMBMAX = 50;
  localparam int REQMAX = 30;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] cfgSel = 2'b00;
  logic selfPw = 1'b0;
  logic suspendEnter = 1'b0;
  logic reqActive = 1'b0;
  logic [7:0] memDelay = 8'h00;
  logic hostGo = 1'b0;
  logic memLoadDone, usbBusReset, hubOutputsDriven, operational, memLoadReq, upstreamAttach;
  logic configured, hubSuspended, ttFlush, reqAbort;
  logic [6:0] devAddress;
  logic [3:0] portPwr, chgEn, portRst;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rd;
  int fails = 0, checked = 0, cyc = 0, rel = 0, flushSeen = 0, abortSeen = 0;
  logic [3:0] rstMask = 4'h0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ttFlush === 1'b1) flushSeen <= flushSeen + 1;
    if (reqAbort === 1'b1) abortSeen <= abortSeen + 1;
    rstMask <= rstMask | portRst;
  end
  hrcs_sequencer #(.NPORTS(4), .OPER_CYC(OPER), .MEM_MAX_CYC(MEMMAX), .SMB_MAX_CYC(SMBMAX),
    .REQ_MAX_CYC(REQMAX)) dut (.clk(clk), .rstn(rstn), .cfgSelPin(cfgSel),
    .selfPoweredPin(selfPw), .memLoadDone(memLoadDone), .usbBusReset(usbBusReset),
    .suspendEnter(suspendEnter), .resumeDetect(1'b0), .reqActive(reqActive),
    .hubOutputsDriven(hubOutputsDriven), .operational(operational), .memLoadReq(memLoadReq),
    .upstreamAttach(upstreamAttach), .devAddress(devAddress), .configured(configured),
    .hubSuspended(hubSuspended), .ttFlush(ttFlush), .reqAbort(reqAbort),
    .downstreamPortPowerEn(portPwr), .chargingPortEnable(chgEn), .downstreamPortReset(portRst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  hrcs_far_model #(.HOLDOFF(40)) far (.clk(clk), .rstn(rstn), .memLoadReq(memLoadReq),
    .upstreamAttach(upstreamAttach), .memDelay(memDelay), .hostResetGo(hostGo),
    .memLoadDone(memLoadDone), .usbBusReset(usbBusReset));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit got;
    got = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        got = 1;
        resp = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic axr(input logic [7:0] a);
    bit got;
    got = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        got = 1;
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  task automatic waitFor(ref logic sig, input int maxn, input string nm);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < maxn) begin
      @(posedge clk);
      n++;
    end
    chk(nm, {31'h0, sig}, 32'h1);
  endtask
  task automatic boot(input logic [1:0] c, input logic sp, input logic [1:0] path);
    @(posedge clk);
    rstn <= 1'b0;
    cfgSel <= c;
    selfPw <= sp;
    repeat (10) @(posedge clk);
    rstn <= 1'b1; // low for 10 clocks, 50 ns, short of the 1 us minimum
    rel = cyc + 1;
    @(posedge clk);
    waitFor(operational, OPER + 2, "operational");
    axr(`HRCS_REG_STATUS);
    chk("path", {30'h0, rd[`HRCS_ST_PATH_LSB +: 2]}, {30'h0, path});
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    boot(2'b11, 1'b0, HRCS_CFG_RSVD);
    waitFor(upstreamAttach, 10, "attach strap11");
    boot(2'b00, 1'b0, HRCS_CFG_STRAP);
    waitFor(upstreamAttach, 10, "attach strap");
    while (cyc < rel + 401) @(posedge clk);
    chk("outputs driven", {31'h0, hubOutputsDriven}, 32'h1);
    memDelay <= 8'h0c;
    boot(2'b01, 1'b0, HRCS_CFG_MEM);
    waitFor(upstreamAttach, MEMMAX + 10, "attach mem");
    axr(`HRCS_REG_STATUS);
    chk("mem err clear", {31'h0, rd[`HRCS_ST_MEMERR]}, 32'h0);
    memDelay <= 8'h00;
    boot(2'b01, 1'b0, HRCS_CFG_MEM);
    waitFor(upstreamAttach, MEMMAX + 10, "attach mem timeout");
    axr(`HRCS_REG_STATUS);
    chk("mem err set", {31'h0, rd[`HRCS_ST_MEMERR]}, 32'h1);
    chk("mem req off", {31'h0, memLoadReq}, 32'h0);
    boot(2'b10, 1'b1, HRCS_CFG_SMB);
    repeat (SMBMAX + 30) @(posedge clk);
    chk("self wait", {31'h0, upstreamAttach}, 32'h0);
    axr(`HRCS_REG_STATUS);
    chk("self no late", {31'h0, rd[`HRCS_ST_SMBLATE]}, 32'h0);
    axw(`HRCS_REG_CTRL, 32'h1, 4'h1);
    waitFor(upstreamAttach, 10, "attach self");
    boot(2'b10, 1'b0, HRCS_CFG_SMB);
    repeat (SMBMAX + 10) @(posedge clk);
    axr(`HRCS_REG_STATUS);
    chk("bus late", {31'h0, rd[`HRCS_ST_SMBLATE]}, 32'h1);
    chk("bus wait", {31'h0, upstreamAttach}, 32'h0);
    axw(`HRCS_REG_CTRL, 32'h1, 4'h1);
    waitFor(upstreamAttach, 10, "attach bus");
    axw(`HRCS_REG_DEVADDR, 32'h2a, 4'h1);
    axw(`HRCS_REG_CONFIG, 32'h1, 4'h1);
    axw(`HRCS_REG_PORTPWR, 32'hf, 4'h1);
    axw(`HRCS_REG_CHARGE, 32'h5, 4'h1);
    chk("configured", {31'h0, configured}, 32'h1);
    @(posedge clk);
    suspendEnter <= 1'b1;
    @(posedge clk);
    suspendEnter <= 1'b0;
    repeat (2) @(posedge clk);
    chk("suspended", {31'h0, hubSuspended}, 32'h1);
    flushSeen = 0;
    rstMask = 4'h0;
    hostGo <= 1'b1;
    repeat (60) @(posedge clk);
    hostGo <= 1'b0;
    chk("dev addr", {25'h0, devAddress}, 32'h0);
    chk("unconfigured", {31'h0, configured}, 32'h0);
    chk("port power", {28'h0, portPwr}, 32'h5);
    chk("charge en", {28'h0, chgEn}, 32'h5);
    chk("flush count", flushSeen, 32'h1);
    chk("active", {31'h0, hubSuspended}, 32'h0);
    chk("no port reset", {28'h0, rstMask}, 32'h0);
    axr(`HRCS_REG_DEVADDR);
    chk("dev addr reg", rd, 32'h0);
    abortSeen = 0;
    @(posedge clk);
    reqActive <= 1'b1;
    repeat (REQMAX + 10) @(posedge clk);
    reqActive <= 1'b0;
    chk("abort count", abortSeen, 32'h1);
    axr(`HRCS_REG_STATUS);
    chk("req timeout", {31'h0, rd[`HRCS_ST_REQTMO]}, 32'h1);
    axw(`HRCS_REG_STATUS, 32'h800, 4'h2);
    axr(`HRCS_REG_STATUS);
    chk("req timeout clear", {31'h0, rd[`HRCS_ST_REQTMO]}, 32'h0);
    axw(`HRCS_REG_PORTRST, 32'h3, 4'h1);
    repeat (2) @(posedge clk);
    chk("port reset pulses", {28'h0, rstMask}, 32'h3);
    axr(8'h1c);
    chk("unmapped rresp", {30'h0, resp}, {30'h0, `HRCS_RESP_SLVERR});
    chk("unmapped rdata", rd, 32'h0);
    axw(8'h20, 32'h1, 4'h1);
    chk("unmapped bresp", {30'h0, resp}, {30'h0, `HRCS_RESP_SLVERR});
    tally_and_finish();
  end
endmodule
